// File: common/eee_config_consts.svh
`ifndef EEE_CONFIG_CONSTS_SVH
`define EEE_CONFIG_CONSTS_SVH

// register addresses inside the extended register space
`define EEE_CFG3_ADDR        16'h04d1
`define EEE_LINK_TIMING_ADDR 16'h04d2
`define EEE_STEP_GAINS_ADDR  16'h04d4

// reset values
`define EEE_CFG3_RESET        16'h018b
`define EEE_LINK_TIMING_RESET 16'h354a
`define EEE_STEP_GAINS_RESET  16'h6633

// writable bit masks; reserved bits stay zero
`define EEE_CFG3_WMASK        16'h77ff
`define EEE_LINK_TIMING_WMASK 16'hffff
`define EEE_STEP_GAINS_WMASK  16'h7777

// field positions in the first configuration register
`define FLP_SEL_HI       14
`define FLP_SEL_LO       13
`define FORCE_TX_IDLE_BIT 12
`define ADV_SRC_BIT      3
`define NP_BLOCK_BIT     2
`define QUIET_PD_BIT     1
`define CAP_ON_BIT       0

// forced low-power select encodings
`define FLP_OFF     2'h0
`define FLP_FORCED  2'h3

`endif

// File: common/eee_config_pkg.sv
package eee_config_pkg;

   // decoded forced low-power mode
   typedef enum logic [1:0]
   {
      flp_off,
      flp_reserved,
      flp_forced
   } flp_mode_t;

endpackage

// File: hw/eee_config_registers.sv
`timescale 1ns/100ps
`include "eee_config_consts.svh"

// Notes on behaviour
// - forced select 0 is off, 3 forces low-power idle, 1 and 2 reserved
// - forced transmit idle bit set requests low-power idle on transmit
// - advertise source bit picks capability bit or MMD advertisement registers
// - next page block bit refuses reception of EEE next pages
// - quiet powerdown bit shuts analog receive path in the quiet period
// - capability bit clear reports no EEE support and ignores MMD registers
module eee_config_registers
   import eee_config_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic [15:0] i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_mmd_adv_eee,
   input  wire logic        i_mmd_cap_eee,
   output logic      [15:0] o_reg_rdata,
   output logic      [1:0]  o_flp_mode,
   output logic             o_tx_lpi_request,
   output logic             o_adv_eee,
   output logic             o_np_accept,
   output logic             o_quiet_rx_powerdown,
   output logic             o_eee_supported,
   output logic      [15:0] o_link_timing,
   output logic      [15:0] o_step_gains
);

   // ****************************************
   // register storage
   // ****************************************

   logic [15:0] cfg3_reg;
   logic [15:0] timing_reg;
   logic [15:0] gains_reg;
   flp_mode_t   flp_mode;

   // merge a write through a writable-bit mask
   function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
      masked = d & m;
   endfunction

   // first configuration register, reserved bits forced to zero
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         cfg3_reg <= `EEE_CFG3_RESET;
      else if (i_reg_wr && i_reg_addr == `EEE_CFG3_ADDR)
         cfg3_reg <= masked(i_reg_wdata, `EEE_CFG3_WMASK);
   end

   // receive timing loop controls, all bits writable
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         timing_reg <= `EEE_LINK_TIMING_RESET;
      else if (i_reg_wr && i_reg_addr == `EEE_LINK_TIMING_ADDR)
         timing_reg <= masked(i_reg_wdata, `EEE_LINK_TIMING_WMASK);
   end

   // step gains; bits 15, 11, 7 and 3 are reserved
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         gains_reg <= `EEE_STEP_GAINS_RESET;
      else if (i_reg_wr && i_reg_addr == `EEE_STEP_GAINS_ADDR)
         gains_reg <= masked(i_reg_wdata, `EEE_STEP_GAINS_WMASK);
   end

   // ****************************************
   // read path
   // ****************************************

   // unmapped addresses read zero
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_reg_rdata <= 16'h0000;
      else
      begin
         case (i_reg_addr)
            `EEE_CFG3_ADDR:        o_reg_rdata <= cfg3_reg;
            `EEE_LINK_TIMING_ADDR: o_reg_rdata <= timing_reg;
            `EEE_STEP_GAINS_ADDR:  o_reg_rdata <= gains_reg;
            default:               o_reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ****************************************
   // control decode
   // ****************************************

   // reserved select codes decode as flp_reserved, not as off, so a stray write never reports forced idle
   // limitation: the decode only reports the mode; the transmit path that
   // acts on it lies outside this bank and must itself ignore reserved codes
   always_comb
   begin
      case (cfg3_reg[`FLP_SEL_HI:`FLP_SEL_LO])
         `FLP_OFF:    flp_mode = flp_off;
         `FLP_FORCED: flp_mode = flp_forced;
         default:     flp_mode = flp_reserved;
      endcase
   end

   // outputs follow the stored bits; capability gate sits last
   always_comb
   begin
      o_flp_mode           = flp_mode;
      // the request bit is honoured as written; ordering is the host's duty
      o_tx_lpi_request     = cfg3_reg[`FORCE_TX_IDLE_BIT];
      o_eee_supported      = cfg3_reg[`CAP_ON_BIT] & i_mmd_cap_eee;
      o_adv_eee            = cfg3_reg[`ADV_SRC_BIT] ? cfg3_reg[`CAP_ON_BIT]
                             : (cfg3_reg[`CAP_ON_BIT] & i_mmd_adv_eee);
      o_np_accept          = ~cfg3_reg[`NP_BLOCK_BIT];
      o_quiet_rx_powerdown = cfg3_reg[`QUIET_PD_BIT];
      o_link_timing        = timing_reg;
      o_step_gains         = gains_reg;
   end

   // ****************************************
   // checks
   // ****************************************

   reserved_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (cfg3_reg & ~`EEE_CFG3_WMASK) == 16'h0 && (gains_reg & ~`EEE_STEP_GAINS_WMASK) == 16'h0)
      else $error("reserved bit set");
   cfg3_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_wr && i_reg_addr == `EEE_CFG3_ADDR |=> cfg3_reg == ($past(i_reg_wdata) & 16'h77ff))
      else $error("config write not stored");
   forced_mode_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (flp_mode == flp_forced) == (cfg3_reg[14:13] == 2'h3))
      else $error("forced mode decode wrong");
   tx_request_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_wr && i_reg_addr == `EEE_CFG3_ADDR |=> o_tx_lpi_request == $past(i_reg_wdata[12]))
      else $error("transmit idle request wrong");
   adv_source_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cfg3_reg[3] |-> o_adv_eee == cfg3_reg[0])
      else $error("advertise source wrong");
   no_support_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !cfg3_reg[0] |-> !o_eee_supported && !o_adv_eee)
      else $error("support reported while disabled");
   np_block_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_np_accept != cfg3_reg[2])
      else $error("next page gate wrong");
   quiet_pd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_wr && i_reg_addr == `EEE_CFG3_ADDR
      |=> o_quiet_rx_powerdown == $past(i_reg_wdata[1]))
      else $error("quiet powerdown wrong");
   unmapped_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_addr == 16'h04d3 |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");

   // ****************************************
   // register write and read checks
   // ****************************************

   // timing register takes every bit of a write
   timing_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_wr && i_reg_addr == `EEE_LINK_TIMING_ADDR
      |=> o_link_timing == $past(i_reg_wdata))
      else $error("timing write not stored");

   // gains register drops the reserved bits of a write
   gains_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_wr && i_reg_addr == `EEE_STEP_GAINS_ADDR
      |=> o_step_gains == ($past(i_reg_wdata) & `EEE_STEP_GAINS_WMASK))
      else $error("gains write not stored");

   // a write to any other address leaves the first register alone
   cfg3_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !(i_reg_wr && i_reg_addr == `EEE_CFG3_ADDR) |=> $stable(cfg3_reg))
      else $error("config changed without a write");

   // reads return the register as it stood at the address edge
   cfg3_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_addr == `EEE_CFG3_ADDR |=> o_reg_rdata == $past(cfg3_reg))
      else $error("config read wrong");

   // same for the timing register
   timing_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_addr == `EEE_LINK_TIMING_ADDR |=> o_reg_rdata == $past(timing_reg))
      else $error("timing read wrong");

   // ****************************************
   // decode checks
   // ****************************************

   // reserved select codes never decode as forced
   reserved_code_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cfg3_reg[`FLP_SEL_HI:`FLP_SEL_LO] inside {2'h1, 2'h2} |-> flp_mode == flp_reserved)
      else $error("reserved code decode wrong");

   // select zero reports the off mode
   forced_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cfg3_reg[`FLP_SEL_HI:`FLP_SEL_LO] == `FLP_OFF |-> o_flp_mode == flp_off)
      else $error("off mode decode wrong");

   // with the source bit clear the management advertisement decides
   mmd_source_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !cfg3_reg[`ADV_SRC_BIT] |-> o_adv_eee == (cfg3_reg[`CAP_ON_BIT] & i_mmd_adv_eee))
      else $error("management advertise wrong");

   // support needs both the capability bit and the capability input
   supported_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_eee_supported == (cfg3_reg[`CAP_ON_BIT] & i_mmd_cap_eee))
      else $error("support flag wrong");

   // the transmit request follows its stored bit at every edge
   tx_level_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_tx_lpi_request == cfg3_reg[`FORCE_TX_IDLE_BIT])
      else $error("transmit request level wrong");

   // the quiet powerdown follows its stored bit at every edge
   quiet_level_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_quiet_rx_powerdown == cfg3_reg[`QUIET_PD_BIT])
      else $error("quiet powerdown level wrong");

   forced_cov: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      flp_mode == flp_forced ##1 o_tx_lpi_request);
   mmd_adv_cov: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      !cfg3_reg[3] && o_adv_eee);
   np_block_cov: cover property (@(posedge i_mclk) disable iff (!i_rst_n) !o_np_accept);
   reserved_code_cov: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      flp_mode == flp_reserved);
   unmapped_read_cov: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_reg_addr == 16'h04d3 && !i_reg_wr);

endmodule

// File: testbench/mgmt_host.sv
`timescale 1ns/100ps
// management host: changes the register port only at falling edges
module mgmt_host
(
   input  wire logic        i_mclk,
   input  wire logic [15:0] i_rdata,
   output logic      [15:0] o_addr,
   output logic             o_wr,
   output logic      [15:0] o_wdata
);
   initial
   begin
      o_addr  = 16'h0000;
      o_wr    = 1'b0;
      o_wdata = 16'h0000;
   end
   // one-cycle strobe; data is scrambled after it so a late sample shows up
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
   begin
      @(negedge i_mclk);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_mclk);
      o_wr    = 1'b0;
      o_wdata = ~d;
   end
   endtask
   // read data is registered, so it is taken one edge after the address
   task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
   begin
      @(negedge i_mclk);
      o_addr = a;
      @(negedge i_mclk);
      d = i_rdata;
   end
   endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        mmd_adv = 1'b0;
   logic        mmd_cap = 1'b0;
   logic [15:0] addr, wdata, rdata, timing, gains;
   logic [1:0]  mode;
   logic        wr, lpi, adv, npa, pd, sup;
   int          fails = 0;
   int          checked = 0;

   always #50 mclk = ~mclk;

   mgmt_host host (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
   eee_config_registers dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .i_mmd_adv_eee(mmd_adv), .i_mmd_cap_eee(mmd_cap),
      .o_reg_rdata(rdata), .o_flp_mode(mode), .o_tx_lpi_request(lpi), .o_adv_eee(adv),
      .o_np_accept(npa), .o_quiet_rx_powerdown(pd), .o_eee_supported(sup),
      .o_link_timing(timing), .o_step_gains(gains));

   // ******************************
   // scenarios
   // ******************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
   begin
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
   begin
      host.rd_reg(a, d);
      check(d, exp);
   end
   endtask
   task automatic reset_values();
   begin
      rd(16'h04d1, 16'h018b);
      rd(16'h04d2, 16'h354a);
      rd(16'h04d4, 16'h6633);
      rd(16'h04d3, 16'h0000);
      check({10'h000, mode, lpi, adv, npa, pd}, 16'h0007);
   end
   endtask
   task automatic reserved_bits();
   begin
      host.wr_reg(16'h04d1, 16'h6fff);
      host.wr_reg(16'h04d1, 16'hffff);
      host.wr_reg(16'h04d2, 16'hffff);
      host.wr_reg(16'h04d4, 16'hffff);
      host.wr_reg(16'h04d3, 16'hffff);
      rd(16'h04d1, 16'h77ff);
      rd(16'h04d4, 16'h7777);
      rd(16'h04d3, 16'h0000);
      check(timing, 16'hffff);
      check(gains, 16'h7777);
   end
   endtask
   // codes 1 and 2 must not force idle; request only after select is 3
   task automatic forced_modes();
      logic [1:0] want [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
   begin
      for (int c = 0; c < 4; c++)
      begin
         host.wr_reg(16'h04d1, {1'b0, 2'(c), 13'h0000});
         check({14'h0000, mode}, {14'h0000, want[c]});
         check({15'h0000, lpi}, 16'h0000);
      end
      host.wr_reg(16'h04d1, 16'h7000);
      check({15'h0000, lpi}, 16'h0001);
      host.wr_reg(16'h04d1, 16'h6000);
      check({15'h0000, lpi}, 16'h0000);
   end
   endtask
   // every setting of bits 3..0 against every level of the two mmd inputs
   task automatic capability_map();
      logic [3:0] b;
      logic       e;
   begin
      for (int i = 0; i < 64; i++)
      begin
         b = 4'(i);
         {mmd_adv, mmd_cap} = 2'(i >> 4);
         host.wr_reg(16'h04d1, {12'h000, b});
         e = b[3] ? b[0] : (b[0] & mmd_adv);
         check({15'h0000, adv}, {15'h0000, e});
         check({15'h0000, npa}, {15'h0000, ~b[2]});
         check({15'h0000, pd}, {15'h0000, b[1]});
         check({15'h0000, sup}, {15'h0000, b[0] & mmd_cap});
      end
   end
   endtask
   task automatic complete_run();
   begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   // main sequence; reset is released at a falling edge
   initial
   begin
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      reset_values();
      reserved_bits();
      forced_modes();
      capability_map();
      complete_run();
   end
   // watchdog: the tests need some 166 cycles
   initial
   begin
      #100000;
      fails++;
      complete_run();
   end
endmodule
